// ==== bcm_crc6.sv ====
/*
  Combinational six-bit CRC over a data word, MSB first.
  Assumes the word is stable while its result is used.
*/
`timescale 1ns/10ps
`default_nettype none
module bcm_crc6
  import bcm_pkg::*;
#(
  parameter int DATA_W = 30
) (
  // Data
  input wire logic [DATA_W-1:0] i_data,
  // Result, not inverted
  output logic [CRC_W-1:0] o_crc
);

  // ----------------------------------------
  // Serial CRC unrolled over the word
  // ----------------------------------------
  always_comb
  begin
    logic [CRC_W-1:0] acc;
    logic fb;
    acc = CRC_INIT;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--)
    begin
      fb = acc[CRC_W-1] ^ i_data[i];
      acc = {acc[CRC_W-2:0], 1'b0};
      if (fb)
      begin
        acc = acc ^ CRC_POLY;
      end
    end
    o_crc = acc;
  end

endmodule
`default_nettype wire

// ==== bcm_master_model.sv ====
/*
  Behavioural link master: clocks one frame and samples the data line.
  Assumes the slave line delay stays below half a link period.
*/
`timescale 1ns/10ps
`default_nettype none
module bcm_master_model
(
  // Link
  input wire logic i_sl,
  output logic o_ma
);
  // ----------------------------------------
  // Frame clocking
  // ----------------------------------------
  localparam int HALF_NS = 500;
  // Keeps link edges off the system clock edges
  localparam int PHASE_NS = 7;
  // Clock line idles high between frames
  initial o_ma = 1'b1;
  task automatic run_frame(input int nedges, output logic [63:0] got);
    got = 64'h0;
    #(PHASE_NS);
    o_ma = 1'b0;
    for (int e = 1; e <= nedges; e++)
    begin
      #(HALF_NS);
      o_ma = 1'b1;
      #(HALF_NS);
      if (e >= 3)
        got = {got[62:0], i_sl};
      if (e < nedges)
        o_ma = 1'b0;
    end
    #(20000);
  endtask
endmodule
`default_nettype wire

// ==== bcm_pkg.sv ====
/*
  Shared constants and types of the multi-turn serial position slave.
  Assumes a 20 MHz system clock and a master link clock of 600 kHz to 2 MHz.
*/
// Functional notes
// - Turn count is an unsigned 12-bit value, zero up to 4095.
// - Single-cycle data word is 24 to 36 bits, set by position resolution.
// - Slave spends 12 master clock periods of processing before its data.
// - Data area is resolution plus twelve turn bits plus two flag bits.
// - Six-bit CRC, polynomial 0x43, start zero, sent inverted.
// - MSB first: turn bits, then position bits, then the two flags.
// - Position-valid flag high when the position is valid, else low.
// - Last data bit, turn-count-valid flag, high when turn count valid.
// - Master drives the clock line; slave answers on the data line.
// - Each frame carries the reading captured at the previous frame trigger.
package bcm_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int TIMEOUT_NS = 15000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_CNT_W = 9;
  localparam logic [IDLE_CNT_W-1:0] TIMEOUT_LAST = IDLE_CNT_W'(TIMEOUT_CYC - 1);

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int PROC_CYC = 12;
  localparam int TURN_W = 12;
  localparam int FLAG_W = 2;
  localparam int CRC_W = 6;
  localparam logic [CRC_W-1:0] CRC_POLY = 6'h03;
  localparam logic [CRC_W-1:0] CRC_INIT = 6'h00;
  localparam int POS_MIN_W = 10;
  localparam int POS_MAX_W = 22;
  localparam int POS_DEF_W = 16;
  localparam int CNT_W = 6;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [TURN_W-1:0] turns;
    logic [POS_MAX_W-1:0] position;
    logic position_valid_flag;
    logic turn_count_valid_flag;
  } bcm_reading_t;

  typedef enum logic [5:0] {
    L_IDLE = 6'h01,
    L_ACK = 6'h02,
    L_START = 6'h04,
    L_CDS = 6'h08,
    L_DATA = 6'h10,
    L_HOLD = 6'h20
  } bcm_link_state_t;

endpackage

// ==== bcm_slave.sv ====
/*
  Unidirectional serial position slave: frames turn count, position, flags
  and inverted CRC onto the data line, clocked by the master's link clock.
  Assumes the link clock idles high and stands still between frames, and
  that the sensor reading arrives on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module bcm_slave
  import bcm_pkg::*;
#(
  parameter int POS_W = POS_DEF_W
) (
  // System clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Sensor reading
  input wire bcm_reading_t i_reading,
  // Link
  input wire logic i_ma_clk,
  output logic o_sl,
  // Status
  output logic o_trigger
);

  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam int DATA_W = POS_W + TURN_W + FLAG_W;
  localparam int FRAME_W = DATA_W + CRC_W;
  localparam logic [CNT_W-1:0] ACK_LAST = CNT_W'(PROC_CYC - 1);
  localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_W - 1);

  // ----------------------------------------
  // Crossing signals
  // ----------------------------------------
  logic ma_s;
  logic sl_s;
  logic ftog_s;
  logic rearm_l;
  logic ce_l;
  logic frame_tog;
  logic sl_link;
  logic rearm_tog;

  bcm_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_ma (
    .i_clk(i_clock),
    .i_arst(i_rst),
    .i_d(i_ma_clk),
    .o_q(ma_s)
  );

  bcm_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_sl (
    .i_clk(i_clock),
    .i_arst(i_rst),
    .i_d(sl_link),
    .o_q(sl_s)
  );

  bcm_sync2 #(
    .RESET_VAL(1'b0)
  ) u_sync_ftog (
    .i_clk(i_clock),
    .i_arst(i_rst),
    .i_d(frame_tog),
    .o_q(ftog_s)
  );

  bcm_sync2 #(
    .RESET_VAL(1'b0)
  ) u_sync_rearm (
    .i_clk(i_ma_clk),
    .i_arst(i_rst),
    .i_d(rearm_tog),
    .o_q(rearm_l)
  );

  bcm_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_ce (
    .i_clk(i_ma_clk),
    .i_arst(i_rst),
    .i_d(i_ce),
    .o_q(ce_l)
  );

  // ----------------------------------------
  // System domain: timeout, release, capture
  // ----------------------------------------
  logic [IDLE_CNT_W-1:0] idle_cnt;
  logic [IDLE_CNT_W-1:0] next_idle_cnt;
  logic release_line;
  logic next_release_line;
  logic next_rearm_tog;
  logic ftog_seen;
  logic next_ftog_seen;
  logic [DATA_W-1:0] tx_data;
  logic [DATA_W-1:0] next_tx_data;
  logic next_o_sl;
  logic next_o_trigger;
  logic frame_new;
  logic timeout_hit;

  always_comb
  begin
    frame_new = ftog_s != ftog_seen;
    timeout_hit = ma_s && (idle_cnt == TIMEOUT_LAST) && !release_line;
    next_idle_cnt = idle_cnt;
    next_release_line = release_line;
    next_rearm_tog = rearm_tog;
    next_ftog_seen = ftog_s;
    next_tx_data = tx_data;
    next_o_trigger = frame_new;
    if (!ma_s)
    begin
      next_idle_cnt = '0;
    end
    else if (idle_cnt != TIMEOUT_LAST)
    begin
      next_idle_cnt = idle_cnt + 1'b1;
    end
    if (frame_new)
    begin
      next_release_line = 1'b0;
      // Reading taken now is sent by the next frame
      next_tx_data = {i_reading.turns,
                      i_reading.position[POS_W-1:0],
                      i_reading.position_valid_flag,
                      i_reading.turn_count_valid_flag};
    end
    else if (timeout_hit)
    begin
      next_release_line = 1'b1;
      next_rearm_tog = ~rearm_tog;
    end
    next_o_sl = next_release_line ? 1'b1 : sl_s;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      idle_cnt <= '0;
      release_line <= 1'b1;
      // Armed from reset, first frame starts on third edge
      rearm_tog <= 1'b1;
      ftog_seen <= 1'b0;
      tx_data <= '0;
      o_sl <= 1'b1;
      o_trigger <= 1'b0;
    end
    else if (i_ce)
    begin
      idle_cnt <= next_idle_cnt;
      release_line <= next_release_line;
      rearm_tog <= next_rearm_tog;
      ftog_seen <= next_ftog_seen;
      tx_data <= next_tx_data;
      o_sl <= next_o_sl;
      o_trigger <= next_o_trigger;
    end
  end

  // ----------------------------------------
  // Frame CRC
  // ----------------------------------------
  logic [CRC_W-1:0] crc;

  bcm_crc6 #(
    .DATA_W(DATA_W)
  ) u_crc (
    .i_data(tx_data),
    .o_crc(crc)
  );

  // ----------------------------------------
  // Link domain: frame sequencer
  // ----------------------------------------
  bcm_link_state_t state;
  bcm_link_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [FRAME_W-1:0] shreg;
  logic [FRAME_W-1:0] next_shreg;
  logic next_sl_link;
  logic next_frame_tog;
  logic rearm_seen;
  logic next_rearm_seen;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_sl_link = sl_link;
    next_frame_tog = frame_tog;
    next_rearm_seen = rearm_l;
    if (rearm_l != rearm_seen)
    begin
      // New frame after reset or after a full timeout
      next_state = L_ACK;
      next_cnt = ACK_LAST;
      next_shreg = {tx_data, ~crc};
      next_sl_link = 1'b0;
      next_frame_tog = ~frame_tog;
    end
    else
    begin
      case (state)
        L_IDLE:
        begin
          next_sl_link = 1'b1;
        end
        L_ACK:
        begin
          if (cnt == '0)
          begin
            next_state = L_START;
            next_sl_link = 1'b1;
          end
          else
          begin
            next_cnt = cnt - 1'b1;
          end
        end
        L_START:
        begin
          next_state = L_CDS;
          next_sl_link = 1'b0;
        end
        L_CDS:
        begin
          next_state = L_DATA;
          next_cnt = FRAME_LAST;
          next_sl_link = shreg[FRAME_W-1];
          next_shreg = {shreg[FRAME_W-2:0], 1'b0};
        end
        L_DATA:
        begin
          if (cnt == '0)
          begin
            next_state = L_HOLD;
            next_sl_link = 1'b0;
          end
          else
          begin
            next_cnt = cnt - 1'b1;
            next_sl_link = shreg[FRAME_W-1];
            next_shreg = {shreg[FRAME_W-2:0], 1'b0};
          end
        end
        L_HOLD:
        begin
          next_sl_link = 1'b0;
        end
        default:
        begin
          next_state = L_HOLD;
          next_sl_link = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ma_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= L_IDLE;
      cnt <= '0;
      shreg <= '0;
      sl_link <= 1'b1;
      frame_tog <= 1'b0;
      rearm_seen <= 1'b0;
    end
    else if (ce_l)
    begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      sl_link <= next_sl_link;
      frame_tog <= next_frame_tog;
      rearm_seen <= next_rearm_seen;
    end
  end

endmodule
`default_nettype wire

// ==== bcm_slave_monitor.sv ====
/*
  Concurrent checks on the ports of the serial position slave.
  Assumes a link clock that idles high and a period of at least ten system cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module bcm_slave_monitor
  import bcm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Watched inputs
  input wire logic i_ce,
  input wire bcm_reading_t i_reading,
  input wire logic i_ma_clk,
  // Watched outputs
  input wire logic o_sl,
  input wire logic o_trigger
);
  // ----------------------------------------
  // Link clock high time
  // ----------------------------------------
  logic [9:0] hi_cnt;
  logic [9:0] next_hi_cnt;
  always_comb
  begin
    next_hi_cnt = hi_cnt;
    if (i_rst || !i_ma_clk)
      next_hi_cnt = 10'h000;
    else if (hi_cnt != 10'h3ff)
      next_hi_cnt = hi_cnt + 10'h001;
  end
  always_ff @(posedge i_clock)
  begin
    hi_cnt <= next_hi_cnt;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_reset_idle: assert property (disable iff (1'b0) i_rst |=> o_sl && !o_trigger)
    else $error("Line not idle after reset");
  a_trigger_single: assert property (o_trigger |=> !o_trigger)
    else $error("Trigger longer than one cycle");
  a_ack_after_trigger: assert property (o_trigger |-> ##[0:3] (!o_sl) [*8])
    else $error("Line not low while processing");
  a_idle_line_high: assert property (hi_cnt >= TIMEOUT_CYC + 8 |-> o_sl)
    else $error("Line not released after timeout");
  a_idle_no_trigger: assert property (hi_cnt >= 10'd40 |-> !o_trigger)
    else $error("Trigger without link clock");
  a_fall_needs_clock: assert property ($fell(o_sl) |-> hi_cnt < 10'd40)
    else $error("Line fell without link clock");
  a_rise_timing: assert property ($rose(o_sl) |-> hi_cnt < 10'd40 ||
    (hi_cnt >= TIMEOUT_CYC - 2 && hi_cnt <= TIMEOUT_CYC + 8)) else $error("Line rose at wrong time");
  a_bit_hold: assert property ($changed(o_sl) |=> $stable(o_sl) [*8])
    else $error("Bit shorter than a link period");
  c_trigger: cover property (o_trigger);
  c_release: cover property ($rose(o_sl) && hi_cnt > 10'd200);
  c_ack: cover property ($fell(o_sl));
endmodule
`default_nettype wire

// ==== bcm_sync2.sv ====
/*
  Two-stage level synchroniser.
  Assumes the input is a level held long against the receiving clock.
*/
`timescale 1ns/10ps
`default_nettype none
module bcm_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst,
  // Level
  input wire logic i_d,
  output logic o_q
);

  logic stage1;

  // ----------------------------------------
  // Two flops, the first read only by the second
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_arst)
  begin
    if (i_arst)
    begin
      stage1 <= RESET_VAL;
      o_q <= RESET_VAL;
    end
    else
    begin
      stage1 <= i_d;
      o_q <= stage1;
    end
  end

endmodule
`default_nettype wire

// ==== test_biss_c_multiturn_position_slave.sv ====
/*
  Self-checking bench of the serial position slave with a queue model.
  Assumes the link master model and the port monitor bound below.
*/
`timescale 1ns/10ps
`default_nettype none
module test_biss_c_multiturn_position_slave
  import bcm_pkg::*;
();
  localparam int POS_W = 10;
  localparam int DW = POS_W + 14;
  localparam int FW = POS_W + 35;
  localparam int NFR = 6;
  logic i_clock;
  logic i_rst;
  logic i_ce;
  bcm_reading_t i_reading;
  logic ma_clk;
  logic o_sl;
  logic o_trigger;
  int error_cnt;
  int tests_run;
  int trig_cnt;
  logic [DW-1:0] exp_q[$];
  always #25 i_clock = ~i_clock;
  always @(posedge i_clock)
    if (o_trigger === 1'b1)
      trig_cnt++;
  bcm_slave #(.POS_W(POS_W)) bcm_slave_inst (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
    .i_reading(i_reading), .i_ma_clk(ma_clk), .o_sl(o_sl), .o_trigger(o_trigger));
  bcm_master_model bcm_master_model_inst (.i_sl(o_sl), .o_ma(ma_clk));
  // ----------------------------------------
  // Model and checks
  // ----------------------------------------
  function automatic logic [5:0] crc_of(input logic [DW-1:0] d);
    logic [5:0] c;
    logic fb;
    c = 6'h00;
    for (int i = DW - 1; i >= 0; i--)
    begin
      fb = c[5] ^ d[i];
      c = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
    end
    return c;
  endfunction
  task automatic check_val(input logic [FW-1:0] got, input logic [FW-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_frame(input int nedges, input logic full);
    logic [63:0] got;
    logic [DW-1:0] d;
    d = exp_q.pop_front();
    exp_q.push_back({i_reading.turns, i_reading.position[POS_W-1:0], i_reading.position_valid_flag,
      i_reading.turn_count_valid_flag});
    bcm_master_model_inst.run_frame(nedges, got);
    if (full)
      check_val(got[FW-1:0], {14'h0002, d, ~crc_of(d), 1'b0});
    check_val(FW'(o_sl), FW'(1));
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    bcm_reading_t r;
    i_clock = 1'b0;
    i_rst = 1'b0;
    i_ce = 1'b1;
    i_reading = '0;
    error_cnt = 0;
    tests_run = 0;
    trig_cnt = 0;
    exp_q.push_back('0);
    void'($urandom(32'hf5021402));
    #(1);
    i_rst = 1'b1;
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int k = 0; k < NFR; k++)
    begin
      @(posedge i_clock);
      r.turns = 12'($urandom());
      r.position = 22'($urandom());
      r.position_valid_flag = 1'($urandom());
      r.turn_count_valid_flag = 1'($urandom());
      if (k < 2)
        r = '{turns: (k == 0) ? 12'hfff : 12'h000, position: r.position,
          position_valid_flag: (k == 0), turn_count_valid_flag: (k == 0)};
      i_reading <= r;
      @(posedge i_clock);
      do_frame((k == 3) ? 20 : FW + 2, k != 3);
    end
    check_val(FW'(trig_cnt), FW'(NFR));
    stop_test();
  end
  initial
  begin
    #(1000000);
    $display("Watchdog expired");
    error_cnt++;
    stop_test();
  end
endmodule
bind bcm_slave bcm_slave_monitor bcm_slave_monitor_inst (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
  .i_reading(i_reading), .i_ma_clk(i_ma_clk), .o_sl(o_sl), .o_trigger(o_trigger));
`default_nettype wire
